// File: hw/rstwd_pkg.sv
package rstwd_pkg;

	// System clock and watchdog oscillator
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned WDOG_OSC_HZ = 128_000;
	localparam int unsigned WDOG_TICK_CYCLES = CLK_HZ / WDOG_OSC_HZ;
	localparam int unsigned WDOG_BASE_TICKS = 2048;
	localparam logic [3:0] WDOG_SEL_MAX = 4'h9;
	localparam int unsigned WDOG_DIV_W = 9;
	localparam int unsigned WDOG_TICK_W = 21;

	// Reset stretch time and its cycle count, rounded up
	localparam int unsigned STARTUP_DELAY_NS = 1280;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned STARTUP_DELAY_CYCLES =
		(STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DELAY_W = 12;

	// Protected change window
	localparam logic [7:0] CCP_SIGNATURE = 8'hD8;
	localparam logic [2:0] CCP_WINDOW_CYCLES = 3'h4;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_WDOG_CTRL = 6'h31;
	localparam logic [5:0] IDX_SUPPLY_CTRL = 6'h32;
	localparam logic [5:0] IDX_RESET_CAUSE = 6'h3B;
	localparam logic [5:0] IDX_CCP = 6'h3C;

	// Field positions
	localparam int unsigned WDIF_BIT = 7;
	localparam int unsigned WDOG_IRQ_ENABLE_BIT = 6;
	localparam int unsigned WDP3_BIT = 5;
	localparam int unsigned WDE_BIT = 3;
	localparam int unsigned SUPPLY_LOW_FLAG_BIT = 7;
	localparam int unsigned SUPPLY_LOW_IRQ_EN_BIT = 6;
	localparam int unsigned WDOG_RESET_FLAG_BIT = 3;
	localparam int unsigned EXTRF_BIT = 1;
	localparam int unsigned POWERON_RESET_FLAG_BIT = 0;

	// Supply monitor level codes
	localparam logic [2:0] VLM_OFF = 3'h0;
	localparam logic [2:0] VLM_RST_LO = 3'h1;
	localparam logic [2:0] VLM_RST_HI = 3'h2;
	localparam logic [2:0] VLM_FLAG_LO = 3'h3;
	localparam logic [2:0] VLM_FLAG_HI = 3'h4;

	typedef enum logic [2:0] {
		S_POR,
		S_POR_COUNT,
		S_EXT,
		S_COUNT,
		S_RUN
	} rst_state_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic [WDOG_DIV_W-1:0] div;
		logic [WDOG_TICK_W-1:0] ticks;
		logic timeout;
	} wdog_cnt_s;

endpackage

// File: hw/wdog_counter.sv
`timescale 1ns/1ns
`default_nettype none

// Watchdog period counter on a 128 kHz tick derived from the system clock
module wdog_counter
	import rstwd_pkg::*;
#(
	parameter int unsigned base_ticks = WDOG_BASE_TICKS
)(
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic clear, // Restart the period
	input wire logic [3:0] prescale_sel, // Period select
	output logic timeout // One-cycle expiry pulse
);

	wdog_cnt_s cur;
	wdog_cnt_s next_cur;
	logic [WDOG_TICK_W-1:0] last_tick;

	// Ticks in the selected period; reserved codes take the longest
	function automatic logic [WDOG_TICK_W-1:0] period_ticks(
		input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > WDOG_SEL_MAX) ? WDOG_SEL_MAX : sel;
		return WDOG_TICK_W'(base_ticks << s);
	endfunction

	assign last_tick = period_ticks(prescale_sel) - WDOG_TICK_W'(1);

	// Divider and period count
	always_comb
	begin
		next_cur = cur;
		next_cur.timeout = 1'b0;
		if (clear)
		begin
			next_cur.div = '0;
			next_cur.ticks = '0;
		end
		else if (cur.div == WDOG_DIV_W'(WDOG_TICK_CYCLES - 1))
		begin
			next_cur.div = '0;
			if (cur.ticks >= last_tick)
			begin
				next_cur.ticks = '0;
				next_cur.timeout = 1'b1;
			end
			else
				next_cur.ticks = cur.ticks + WDOG_TICK_W'(1);
		end
		else
			next_cur.div = cur.div + WDOG_DIV_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign timeout = cur.timeout;

	clear_quiet_a: assert property (@(posedge clk) disable iff (srst)
		clear |=> !timeout)
		else $error("watchdog expired right after a clear");

endmodule

`default_nettype wire

// File: hw/reset_and_watchdog_control.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Any reset returns watchdog control, restarts core; supply control on power-on only
// - Power-on and pin hold ports at once, without clock
// - Delay counter stretches reset after sources
// - Three causes: power-on, pin, watchdog
// - Power-on reset reasserts immediately on drop
// - Supply-low flag with optional interrupt
// - Flag clears on level change, zero, recovery
// - Monitor reset holds, then power-up sequence
// - Power-on flag set after supply returns
// - Pin ignored during power-on count
// - Pin release waits for delay count
// - Watchdog reset pulse one cycle, then delay
// - Watchdog counts a 128 kHz tick
// - Restart, disable or reset clears watchdog
// - Ten periods; expiry resets the device
// - Watchdog may interrupt instead of reset at level one
// - Fuse picks safety level one or two
// - Level one disable needs signature window
// - Level two: enable reads one, period protected
// - Watchdog reset flag forces enable on
// - Codes zero to nine double the period
// - Enable bits pick stop, irq, reset, both at level one; level two always resets
module reset_and_watchdog_control
	import rstwd_pkg::*;
#(
	parameter int unsigned wdog_base_ticks = WDOG_BASE_TICKS
)(
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire wb_req_s wb_req, // Wishbone request
	output wb_rsp_s wb_rsp, // Wishbone answer
	input wire logic por_active, // Supply below power-on level
	input wire logic ext_reset_n, // External reset pin
	input wire logic supply_below, // Supply below monitor level
	input wire logic wdog_always_on_fuse, // 0 programmed, 1 not
	input wire logic wdog_restart, // Watchdog restart instruction
	input wire logic wdog_irq_ack, // Watchdog vector taken
	output logic core_reset, // Internal reset to the core
	output logic port_reset, // Immediate port reset
	output logic [2:0] supply_monitor_level, // Level to comparator
	output logic supply_low_irq, // Supply-low interrupt pulse
	output logic wdog_irq // Watchdog interrupt request
);

	typedef struct packed {
		rst_state_e state;
		logic [DELAY_W-1:0] delay_cnt;
		logic por_seen;
		logic wdog_pulse;
		logic core_reset;
		wb_rsp_s rsp;
		logic wdif;
		logic wdog_irq_enable;
		logic wdog_reset_enable;
		logic [3:0] wdog_prescale_sel;
		logic [2:0] ccp_cnt;
		logic vlm_flag;
		logic vlm_ie;
		logic [2:0] vlm_level;
		logic vlm_irq;
		logic poweron_reset_flag;
		logic extrf;
		logic wdog_reset_flag;
		logic wdog_irq;
	} ctrl_s;

	ctrl_s cur;
	ctrl_s next_cur;
	logic req_hit;
	logic wr_go;
	logic [5:0] idx;
	logic [7:0] wd;
	logic vlm_rst;
	logic wde_eff;
	logic running;
	logic win;
	logic wd_reset;
	logic timeout;
	logic wdog_clear;
	logic delay_done;

	// Monitor level classes
	function automatic logic level_resets(input logic [2:0] lvl);
		return lvl == VLM_RST_LO || lvl == VLM_RST_HI;
	endfunction

	function automatic logic level_flags(input logic [2:0] lvl);
		return lvl == VLM_FLAG_LO || lvl == VLM_FLAG_HI;
	endfunction

	// Request decode and shared terms
	assign req_hit = wb_req.cyc && wb_req.stb && !cur.rsp.ack;
	assign wr_go = req_hit && wb_req.we && wb_req.sel[0] &&
		cur.state == S_RUN;
	assign idx = wb_req.adr[7:2];
	assign wd = wb_req.dat[7:0];
	assign vlm_rst = level_resets(cur.vlm_level) && supply_below;
	assign wde_eff = cur.wdog_reset_enable || cur.wdog_reset_flag || !wdog_always_on_fuse;
	assign running = wde_eff || cur.wdog_irq_enable;
	assign win = cur.ccp_cnt != 3'h0;
	assign delay_done =
		cur.delay_cnt == DELAY_W'(STARTUP_DELAY_CYCLES - 1);
	// clear on restart, stop or reset
	assign wdog_clear = wdog_restart || !running || cur.core_reset;

	wdog_counter #(
		.base_ticks(wdog_base_ticks)
	) u_wdog (
		.clk(clk),
		.srst(srst),
		.clear(wdog_clear),
		.prescale_sel(cur.wdog_prescale_sel),
		.timeout(timeout)
	);

	// Register read data
	function automatic logic [7:0] rd_mux(input logic [5:0] i,
		input ctrl_s c, input logic fuse);
		logic [7:0] r;
		r = 8'h00;
		case (i)
			IDX_WDOG_CTRL:
			begin
				r[WDIF_BIT] = c.wdif;
				r[WDOG_IRQ_ENABLE_BIT] = c.wdog_irq_enable;
				r[WDP3_BIT] = c.wdog_prescale_sel[3];
				r[WDE_BIT] = c.wdog_reset_enable || c.wdog_reset_flag || !fuse;
				r[2:0] = c.wdog_prescale_sel[2:0];
			end
			IDX_SUPPLY_CTRL:
			begin
				r[SUPPLY_LOW_FLAG_BIT] = c.vlm_flag;
				r[SUPPLY_LOW_IRQ_EN_BIT] = c.vlm_ie;
				r[2:0] = c.vlm_level;
			end
			IDX_RESET_CAUSE:
			begin
				r[WDOG_RESET_FLAG_BIT] = c.wdog_reset_flag;
				r[EXTRF_BIT] = c.extrf;
				r[POWERON_RESET_FLAG_BIT] = c.poweron_reset_flag;
			end
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// Next state of the whole block
	always_comb
	begin
		next_cur = cur;
		wd_reset = 1'b0;
		// Bus answer one cycle after the request
		next_cur.rsp.ack = req_hit;
		next_cur.rsp.dat = 32'h0000_0000;
		if (req_hit && !wb_req.we)
			next_cur.rsp.dat = {24'h00_0000,
				rd_mux(idx, cur, wdog_always_on_fuse)};
		if (win)
			next_cur.ccp_cnt = cur.ccp_cnt - 3'h1;
		if (wr_go && idx == IDX_CCP && wd == CCP_SIGNATURE)
			next_cur.ccp_cnt = CCP_WINDOW_CYCLES;
		// Watchdog control write
		if (wr_go && idx == IDX_WDOG_CTRL)
		begin
			next_cur.ccp_cnt = 3'h0;
			next_cur.wdog_irq_enable = wd[WDOG_IRQ_ENABLE_BIT];
			if (wd[WDIF_BIT])
				next_cur.wdif = 1'b0;
			if (wdog_always_on_fuse)
			begin
				next_cur.wdog_prescale_sel = {wd[WDP3_BIT], wd[2:0]};
				if (wd[WDE_BIT])
					next_cur.wdog_reset_enable = 1'b1;
				else if (win && !cur.wdog_reset_flag)
					next_cur.wdog_reset_enable = 1'b0;
			end
			else if (win)
				next_cur.wdog_prescale_sel = {wd[WDP3_BIT], wd[2:0]};
		end
		// Vector taken: clear flag; with reset enabled, drop to reset mode
		if (wdog_irq_ack)
		begin
			next_cur.wdif = 1'b0;
			if (wde_eff)
				next_cur.wdog_irq_enable = 1'b0;
		end
		if (timeout && cur.state == S_RUN)
		begin
			if (cur.wdog_irq_enable && wdog_always_on_fuse &&
				!(wde_eff && cur.wdif))
				next_cur.wdif = 1'b1;
			else if (wde_eff)
				wd_reset = 1'b1;
		end
		// Reset cause writes: zero clears a flag
		if (wr_go && idx == IDX_RESET_CAUSE)
		begin
			if (!wd[WDOG_RESET_FLAG_BIT])
				next_cur.wdog_reset_flag = 1'b0;
			if (!wd[EXTRF_BIT])
				next_cur.extrf = 1'b0;
			if (!wd[POWERON_RESET_FLAG_BIT])
				next_cur.poweron_reset_flag = 1'b0;
		end
		// Supply monitor control write
		if (wr_go && idx == IDX_SUPPLY_CTRL)
		begin
			next_cur.vlm_ie = wd[SUPPLY_LOW_IRQ_EN_BIT];
			if (wd[2:0] != cur.vlm_level || !wd[SUPPLY_LOW_FLAG_BIT])
				next_cur.vlm_flag = 1'b0;
			next_cur.vlm_level = wd[2:0];
		end
		if (!supply_below)
			next_cur.vlm_flag = 1'b0;
		next_cur.vlm_irq = 1'b0;
		if (supply_below && level_flags(cur.vlm_level))
		begin
			next_cur.vlm_flag = 1'b1;
			next_cur.vlm_irq = cur.vlm_ie && !cur.vlm_flag;
		end
		// Reset sequencer
		next_cur.wdog_pulse = 1'b0;
		case (cur.state)
			S_POR:
			begin
				if (!por_active && !vlm_rst)
				begin
					next_cur.state = S_POR_COUNT;
					next_cur.delay_cnt = '0;
					if (cur.por_seen)
						next_cur.poweron_reset_flag = 1'b1;
					next_cur.por_seen = 1'b0;
				end
			end
			S_POR_COUNT:
			begin
				if (delay_done)
				begin
					if (!ext_reset_n)
					begin
						next_cur.state = S_EXT;
						next_cur.extrf = 1'b1;
					end
					else
						next_cur.state = S_RUN;
				end
				else
					next_cur.delay_cnt = cur.delay_cnt + DELAY_W'(1);
			end
			S_EXT:
			begin
				if (ext_reset_n)
				begin
					next_cur.state = S_COUNT;
					next_cur.delay_cnt = '0;
				end
			end
			S_COUNT:
			begin
				if (!ext_reset_n)
					next_cur.state = S_EXT;
				else if (delay_done)
					next_cur.state = S_RUN;
				else if (!cur.wdog_pulse)
					next_cur.delay_cnt = cur.delay_cnt + DELAY_W'(1);
			end
			S_RUN:
			begin
				if (!ext_reset_n)
				begin
					next_cur.state = S_EXT;
					next_cur.extrf = 1'b1;
				end
				else if (wd_reset)
				begin
					next_cur.state = S_COUNT;
					next_cur.delay_cnt = '0;
					next_cur.wdog_pulse = 1'b1;
					next_cur.wdog_reset_flag = 1'b1;
				end
			end
			default: next_cur.state = S_POR;
		endcase
		if (por_active)
		begin
			next_cur.state = S_POR;
			next_cur.por_seen = 1'b1;
			next_cur.wdog_reset_flag = 1'b0;
			next_cur.extrf = 1'b0;
			next_cur.vlm_level = VLM_OFF;
			next_cur.vlm_ie = 1'b0;
			next_cur.vlm_flag = 1'b0;
		end
		else if (vlm_rst)
			next_cur.state = S_POR;
		next_cur.core_reset = next_cur.state != S_RUN;
		if (next_cur.core_reset)
		begin
			next_cur.wdif = 1'b0;
			next_cur.wdog_irq_enable = 1'b0;
			next_cur.wdog_reset_enable = 1'b0;
			next_cur.wdog_prescale_sel = 4'h0;
			next_cur.ccp_cnt = 3'h0;
		end
		if (next_cur.wdog_reset_flag)
			next_cur.wdog_reset_enable = 1'b1;
		next_cur.wdog_irq = next_cur.wdif && next_cur.wdog_irq_enable;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cur <= '0;
			cur.state <= S_POR;
			cur.core_reset <= 1'b1;
		end
		else
			cur <= next_cur;
	end

	assign wb_rsp = cur.rsp;
	assign core_reset = cur.core_reset;
	assign supply_monitor_level = cur.vlm_level;
	assign supply_low_irq = cur.vlm_irq;
	assign wdog_irq = cur.wdog_irq;
	assign port_reset = cur.core_reset || por_active || !ext_reset_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Bus answer timing
	bus_ack_a: assert property (req_hit |=> wb_rsp.ack ##1 !wb_rsp.ack)
		else $error("bus ack missing or longer than one cycle");

	por_hold_a: assert property (por_active |=> core_reset)
		else $error("core left running under power-on reset");

	wd_pulse_a: assert property (cur.wdog_pulse |=>
		!cur.wdog_pulse && cur.delay_cnt == '0 && core_reset)
		else $error("watchdog reset pulse wrong");

	poweron_reset_flag_set_a: assert property (cur.state == S_POR && cur.por_seen &&
		!por_active && !vlm_rst |=> cur.poweron_reset_flag)
		else $error("power-on flag not set after restore");

	delay_end_a: assert property ($fell(core_reset) |->
		$past(delay_done))
		else $error("reset released before delay count");

	// enable reads one at level two
	lvl2_wde_a: assert property (!wdog_always_on_fuse &&
		req_hit && !wb_req.we && idx == IDX_WDOG_CTRL |=> wb_rsp.dat[WDE_BIT])
		else $error("enable bit read zero at level two");

	wdog_reset_flag_wde_a: assert property (cur.wdog_reset_flag |-> cur.wdog_reset_enable)
		else $error("enable clear while watchdog flag set");

	vlm_clr_a: assert property (!supply_below |=> !cur.vlm_flag)
		else $error("supply-low flag stayed after recovery");

	ccp_shut_a: assert property (wr_go && idx == IDX_WDOG_CTRL &&
		!win && !wd[WDE_BIT] && cur.wdog_reset_enable && !cur.core_reset &&
		!por_active && !vlm_rst |=> cur.wdog_reset_enable)
		else $error("watchdog disabled outside change window");

endmodule

`default_nettype wire

// File: tb/core_model.sv
`timescale 1ns/1ns
`default_nettype none

// Core side: periodic restart instructions and vector entry
module core_model (
	input wire logic clk, // System clock
	input wire logic kick_en, // Issue periodic restarts
	input wire logic wdog_irq, // Watchdog interrupt request
	output logic wdog_restart, // Restart instruction pulse
	output logic wdog_irq_ack // Vector taken pulse
);
	int unsigned gap = 0;
	logic kick = 1'b0;
	logic seen = 1'b0;
	logic take = 1'b0;

	// restart well inside
	// Restart every 200 cycles, far inside the shortest period
	always @(posedge clk)
	begin
		gap <= (gap == 199) ? 0 : gap + 1;
		kick <= kick_en && (gap == 199);
	end

	// vector taken once
	// Enter the vector one cycle after the request is seen
	always @(posedge clk)
	begin
		seen <= wdog_irq && !take;
		take <= seen && wdog_irq && !take;
	end

	assign wdog_restart = kick;
	assign wdog_irq_ack = take;
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

// Bench: bus tasks and sequenced scenarios
module tb_top
	import rstwd_pkg::*;
;
	localparam logic [7:0] A_WD = {IDX_WDOG_CTRL, 2'b00};
	localparam logic [7:0] A_SM = {IDX_SUPPLY_CTRL, 2'b00};
	localparam logic [7:0] A_RC = {IDX_RESET_CAUSE, 2'b00};
	localparam logic [7:0] A_CP = {IDX_CCP, 2'b00};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic por = 1'b1;
	logic ext_n = 1'b1;
	logic below = 1'b0;
	logic fuse = 1'b1;
	logic kick_en = 1'b0;
	logic restart, irq_ack, core_reset, port_reset, sl_irq, wd_irq;
	logic [2:0] level;
	wb_req_s req = '0;
	wb_rsp_s rsp;
	int error_cnt = 0;
	int samples_checked = 0;
	int sl_cnt = 0;
	int n;

	// 50 MHz clock
	always #10 clk = ~clk;

	// Count supply-low interrupt pulses
	always @(posedge clk)
		if (sl_irq === 1'b1)
			sl_cnt <= sl_cnt + 1;

	reset_and_watchdog_control #(.wdog_base_ticks(4)) DUT (
		.clk(clk), .srst(srst), .wb_req(req), .wb_rsp(rsp),
		.por_active(por), .ext_reset_n(ext_n), .supply_below(below),
		.wdog_always_on_fuse(fuse), .wdog_restart(restart),
		.wdog_irq_ack(irq_ack), .core_reset(core_reset),
		.port_reset(port_reset), .supply_monitor_level(level),
		.supply_low_irq(sl_irq), .wdog_irq(wd_irq));

	core_model PARTNER (.clk(clk), .kick_en(kick_en), .wdog_irq(wd_irq),
		.wdog_restart(restart), .wdog_irq_ack(irq_ack));

	task automatic chk(input string s, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask

	// One classic cycle; held until ack is sampled high
	// No cycle limit here: only the hang guard ends a stuck wait
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h000000, d}};
		do
		begin
			@(posedge clk);
		end
		while (rsp.ack !== 1'b1);
		chk("bus ack", 8'h01, 8'(rsp.ack));
		q = rsp.dat[7:0];
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string s);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(s, e, q);
	endtask

	// Wait for a core reset level, cycles counted in n
	task automatic wait_core(input logic v, input int m);
		n = 0;
		while (core_reset !== v && n < m)
		begin
			@(posedge clk);
			n++;
		end
		chk("core reset level", 8'(v), 8'(core_reset));
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ports held", 8'h01, 8'(port_reset));
		por <= 1'b0;
		repeat (5) @(posedge clk);
		ext_n <= 1'b0;
		repeat (10) @(posedge clk);
		ext_n <= 1'b1;
		wait_core(1'b0, 200);
		chk("startup", 8'h01, 8'(n >= 49 && n <= 55));
		rd(A_RC, 8'h01, "power-on flag");
		rd(8'h10, 8'h00, "unmapped read");
		rd(A_CP, 8'h00, "protect reads zero");
		$display("test power-on done");
		wr(A_RC, 8'h00);
		ext_n <= 1'b0;
		@(negedge clk);
		chk("pin to ports", 8'h01, 8'(port_reset));
		wait_core(1'b1, 5);
		repeat (20) @(posedge clk);
		ext_n <= 1'b1;
		wait_core(1'b0, 200);
		chk("pin release delay", 8'h01, 8'(n >= 64));
		rd(A_RC, 8'h02, "pin flag");
		$display("test external reset done");
		wr(A_SM, 8'h43);
		chk("monitor level", 8'h03, 8'(level));
		below <= 1'b1;
		repeat (5) @(posedge clk);
		chk("supply irq pulses", 8'h01, 8'(sl_cnt));
		rd(A_SM, 8'hC3, "supply flag set");
		below <= 1'b0;
		repeat (5) @(posedge clk);
		rd(A_SM, 8'h43, "supply flag clear");
		wr(A_SM, 8'h01);
		below <= 1'b1;
		wait_core(1'b1, 10);
		repeat (10) @(posedge clk);
		chk("monitor holds", 8'h01, 8'(core_reset));
		below <= 1'b0;
		wait_core(1'b0, 200);
		chk("monitor start-up", 8'h01, 8'(n >= 64));
		wr(A_SM, 8'h00);
		$display("test supply monitor done");
		wr(A_RC, 8'h00);
		wr(A_WD, 8'h08);
		rd(A_WD, 8'h08, "watchdog enabled");
		repeat (1100) @(posedge clk);
		chk("no early expiry", 8'h00, 8'(core_reset));
		wait_core(1'b1, 600);
		wait_core(1'b0, 100);
		chk("wdog stretch", 8'h01, 8'(n >= 64 && n <= 70));
		rd(A_RC, 8'h08, "watchdog flag");
		wr(A_WD, 8'h00);
		rd(A_WD, 8'h08, "enable forced");
		wr(A_RC, 8'h00);
		wr(A_WD, 8'h00);
		rd(A_WD, 8'h08, "disable needs signature");
		wr(A_CP, 8'hD8);
		repeat (6) @(posedge clk);
		wr(A_WD, 8'h00);
		rd(A_WD, 8'h08, "late write ignored");
		wr(A_CP, 8'hD8);
		wr(A_WD, 8'h00);
		rd(A_WD, 8'h00, "protected disable");
		$display("test watchdog reset done");
		wr(A_WD, 8'h08);
		kick_en <= 1'b1;
		repeat (4000) @(posedge clk);
		chk("restarts hold off", 8'h00, 8'(core_reset));
		kick_en <= 1'b0;
		wr(A_CP, 8'hD8);
		wr(A_WD, 8'h40);
		n = 0;
		while (wd_irq !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		chk("watchdog irq", 8'h01, 8'(wd_irq));
		repeat (8) @(posedge clk);
		chk("irq taken", 8'h00, 8'(wd_irq));
		chk("no reset in irq mode", 8'h00, 8'(core_reset));
		wr(A_WD, 8'h00);
		$display("test watchdog irq done");
		srst <= 1'b1;
		fuse <= 1'b0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wait_core(1'b0, 200);
		rd(A_WD, 8'h08, "always on reads one");
		wr(A_WD, 8'h01);
		rd(A_WD, 8'h08, "period locked");
		wr(A_CP, 8'hD8);
		wr(A_WD, 8'h01);
		rd(A_WD, 8'h09, "protected period");
		$display("test safety level two done");
		conclude();
	end
endmodule

`default_nettype wire
